// file: inc/dcm_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef DCM_MAP_SVH
`define DCM_MAP_SVH

`define DCM_OFF_CTRL_SUP   8'h00
`define DCM_OFF_CTRL_DSP   8'h04
`define DCM_OFF_RESULT     8'h08
`define DCM_OFF_CORE_SEL   8'h0c
`define DCM_OFF_IRQ_STAT   8'h10
`define DCM_OFF_IRQ_MASK   8'h14

`define DCM_SEL_LSB        4
`define DCM_SEL_MSB        5
`define DCM_LOCK_MSB       2
`define DCM_SEL_DISABLE    2'h3
`define DCM_SEL_RESET      2'h3
`define DCM_RESULT_RESET   16'h0000
`define DCM_COUNT_MAX      16'hffff

`define DCM_REF_CLK_HZ     32768
`define DCM_WINDOW_EXP     9
`define DCM_WINDOW_LAST    10'h1ff

`endif

// file: inc/dcm_pkg.sv
// types shared by the decoder clock measurement unit
package dcm_pkg;
	typedef logic [1:0] dcm_sel_t;
	typedef enum logic {DCM_IDLE, DCM_MEASURE} dcm_state_t;
endpackage

// file: core/dcm_top.sv
// decoder clock measurement unit with apb register slave
`include "dcm_map.svh"

module dcm_top
(
	// clock and reset
	input  wire logic          ref_clk,
	input  wire logic          reset_n,
	// apb slave
	input  wire logic [7:0]    paddr,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [31:0]   pwdata,
	input  wire logic [3:0]    pstrb,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	// decoder side
	input  wire logic [2:0]    dec_sync_bit,
	input  wire logic [2:0]    dec_locked,
	// 32kHz reference, asynchronous pin
	input  wire logic          ref_32k,
	// interrupt
	output logic               irq
);
	import dcm_pkg::*;

	// reference synchroniser and edge detect
	logic       ref_s1_r;
	logic       ref_s2_r;
	logic       ref_s3_r;
	logic       ref_stable_r;
	logic       ref_stable_nxt;
	logic       ref_rise;

	// registers
	dcm_pkg::dcm_sel_t sel_sup_r;
	dcm_pkg::dcm_sel_t sel_sup_nxt;
	dcm_pkg::dcm_sel_t sel_dsp_r;
	dcm_pkg::dcm_sel_t sel_dsp_nxt;
	logic              core_sel_r;
	logic              core_sel_nxt;
	logic              irq_stat_r;
	logic              irq_stat_nxt;
	logic              irq_mask_r;
	logic              irq_mask_nxt;
	logic [31:0]       prdata_r;
	logic [31:0]       prdata_nxt;
	logic              pready_r;
	logic              pready_nxt;
	logic              pslverr_r;
	logic              pslverr_nxt;
	logic              irq_r;
	logic              irq_nxt;

	// measurement
	dcm_pkg::dcm_state_t state_r;
	dcm_pkg::dcm_state_t state_nxt;
	logic [9:0]          ref_cnt_r;
	logic [9:0]          ref_cnt_nxt;
	logic [15:0]         sync_cnt_r;
	logic [15:0]         sync_cnt_nxt;
	logic [15:0]         result_r;
	logic [15:0]         result_nxt;
	dcm_pkg::dcm_sel_t   chan_r;
	dcm_pkg::dcm_sel_t   chan_nxt;
	logic                meas_done;

	// bus decode
	logic              wr_fire;
	logic              lane0;
	logic              start_req;
	dcm_pkg::dcm_sel_t wr_sel;
	logic [7:0]        ctrl_sup_rd;
	logic [7:0]        ctrl_dsp_rd;

	// the first stage feeds only the second, the change counts once 2 and 3 agree
	always_comb
	begin
		ref_stable_nxt = ref_stable_r;
		if (ref_s2_r == ref_s3_r)
		begin
			ref_stable_nxt = ref_s2_r;
		end
		ref_rise = ref_s2_r & ref_s3_r & ~ref_stable_r;
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ref_s1_r     <= 1'b0;
			ref_s2_r     <= 1'b0;
			ref_s3_r     <= 1'b0;
			ref_stable_r <= 1'b0;
		end
		else
		begin
			ref_s1_r     <= ref_32k;
			ref_s2_r     <= ref_s1_r;
			ref_s3_r     <= ref_s2_r;
			ref_stable_r <= ref_stable_nxt;
		end
	end

	// register readback images, reserved bits 3 and 7:6 are zero
	assign ctrl_sup_rd = {2'h0, sel_sup_r, 1'b0, dec_locked};
	assign ctrl_dsp_rd = {2'h0, sel_dsp_r, 1'b0, dec_locked};

	// write takes effect in the access cycle; pready is high there already
	assign wr_fire = psel & penable & pready_r & pwrite;
	assign lane0   = pstrb[0];
	assign wr_sel  = pwdata[`DCM_SEL_MSB:`DCM_SEL_LSB];

	// only a write to the copy picked by core select may start a window
	always_comb
	begin
		start_req = 1'b0;
		if (wr_fire && lane0 && wr_sel != `DCM_SEL_DISABLE)
		begin
			if (!core_sel_r && paddr == `DCM_OFF_CTRL_SUP)
			begin
				start_req = 1'b1;
			end
			if (core_sel_r && paddr == `DCM_OFF_CTRL_DSP)
			begin
				start_req = 1'b1;
			end
		end
	end

	always_comb
	begin
		sel_sup_nxt  = sel_sup_r;
		sel_dsp_nxt  = sel_dsp_r;
		core_sel_nxt = core_sel_r;
		irq_mask_nxt = irq_mask_r;
		irq_stat_nxt = irq_stat_r;
		prdata_nxt   = prdata_r;
		pready_nxt   = 1'b0;
		pslverr_nxt  = 1'b0;
		// level output trails the status bit by one cycle so irq stays a flop
		irq_nxt      = irq_stat_r & irq_mask_r;
		// both copies store every write with pstrb[0] set, whichever drives the hardware
		if (wr_fire && lane0)
		begin
			case (paddr)
				`DCM_OFF_CTRL_SUP: sel_sup_nxt  = wr_sel;
				`DCM_OFF_CTRL_DSP: sel_dsp_nxt  = wr_sel;
				`DCM_OFF_CORE_SEL: core_sel_nxt = pwdata[0];
				`DCM_OFF_IRQ_MASK: irq_mask_nxt = pwdata[0];
				`DCM_OFF_IRQ_STAT: irq_stat_nxt = irq_stat_r & ~pwdata[0];
				default:           irq_stat_nxt = irq_stat_r;
			endcase
		end
		// a completing window beats a same-cycle clear
		if (meas_done)
		begin
			irq_stat_nxt = 1'b1;
		end
		// setup cycle: answer ready in the access phase with no wait state
		if (psel && !penable)
		begin
			pready_nxt = 1'b1;
			prdata_nxt = 32'h0000_0000;
			case (paddr)
				`DCM_OFF_CTRL_SUP: prdata_nxt[7:0]  = ctrl_sup_rd;
				`DCM_OFF_CTRL_DSP: prdata_nxt[7:0]  = ctrl_dsp_rd;
				`DCM_OFF_RESULT:   prdata_nxt[15:0] = result_r;
				`DCM_OFF_CORE_SEL: prdata_nxt[0]    = core_sel_r;
				`DCM_OFF_IRQ_STAT: prdata_nxt[0]    = irq_stat_r;
				`DCM_OFF_IRQ_MASK: prdata_nxt[0]    = irq_mask_r;
				default:           pslverr_nxt      = 1'b1;
			endcase
			// the result is read-only; writing it is an error
			if (pwrite && paddr == `DCM_OFF_RESULT)
			begin
				pslverr_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sel_sup_r  <= `DCM_SEL_RESET;
			sel_dsp_r  <= `DCM_SEL_RESET;
			core_sel_r <= 1'b0;
			irq_mask_r <= 1'b0;
			irq_stat_r <= 1'b0;
			prdata_r   <= 32'h0000_0000;
			pready_r   <= 1'b0;
			pslverr_r  <= 1'b0;
			irq_r      <= 1'b0;
		end
		else
		begin
			sel_sup_r  <= sel_sup_nxt;
			sel_dsp_r  <= sel_dsp_nxt;
			core_sel_r <= core_sel_nxt;
			irq_mask_r <= irq_mask_nxt;
			irq_stat_r <= irq_stat_nxt;
			prdata_r   <= prdata_nxt;
			pready_r   <= pready_nxt;
			pslverr_r  <= pslverr_nxt;
			irq_r      <= irq_nxt;
		end
	end

	// measurement window; a new request restarts a running one
	always_comb
	begin
		state_nxt    = state_r;
		ref_cnt_nxt  = ref_cnt_r;
		sync_cnt_nxt = sync_cnt_r;
		result_nxt   = result_r;
		chan_nxt     = chan_r;
		meas_done    = 1'b0;
		case (state_r)
			DCM_IDLE:
			begin
				// idle keeps the last result for software to poll
				state_nxt = DCM_IDLE;
			end
			DCM_MEASURE:
			begin
				// no guard on a silent decoder: the count simply stays zero
				if (dec_sync_bit[chan_r] && sync_cnt_r != `DCM_COUNT_MAX)
				begin
					sync_cnt_nxt = sync_cnt_r + 16'h0001;
				end
				if (ref_rise)
				begin
					ref_cnt_nxt = ref_cnt_r + 10'h001;
					if (ref_cnt_r == `DCM_WINDOW_LAST)
					begin
						state_nxt  = DCM_IDLE;
						result_nxt = sync_cnt_nxt;
						meas_done  = 1'b1;
					end
				end
			end
			default:
			begin
				state_nxt = DCM_IDLE;
			end
		endcase
		// a start in the window's last cycle wins and drops that count
		if (start_req)
		begin
			state_nxt    = DCM_MEASURE;
			chan_nxt     = wr_sel;
			ref_cnt_nxt  = 10'h000;
			sync_cnt_nxt = 16'h0000;
			result_nxt   = `DCM_RESULT_RESET;
			meas_done    = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_r    <= DCM_IDLE;
			ref_cnt_r  <= 10'h000;
			sync_cnt_r <= 16'h0000;
			result_r   <= `DCM_RESULT_RESET;
			chan_r     <= 2'h0;
		end
		else
		begin
			state_r    <= state_nxt;
			ref_cnt_r  <= ref_cnt_nxt;
			sync_cnt_r <= sync_cnt_nxt;
			result_r   <= result_nxt;
			chan_r     <= chan_nxt;
		end
	end

	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = pslverr_r;
	assign irq     = irq_r;
endmodule

// file: bench/dcm_properties.sv
// assertion checker for the decoder clock measurement unit
module dcm_properties
(
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        reset_n,
	// apb
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// decoder side and interrupt
	input wire logic [2:0]  dec_sync_bit,
	input wire logic [2:0]  dec_locked,
	input wire logic        ref_32k,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence rd_ctrl_s;
		pready && !pwrite && (paddr == 8'h00 || paddr == 8'h04);
	endsequence
	setup_rdy_a: assert property (setup_s |=> pready && penable)
		else $error("no ready after setup");
	rdy_pulse_a: assert property (pready |=> !pready)
		else $error("ready held too long");
	unmapped_err_a: assert property (setup_s ##1 (pready && paddr > 8'h14) |-> pslverr)
		else $error("no error on unmapped address");
	ro_result_a: assert property (setup_s ##1 (pready && pwrite && paddr == 8'h08) |-> pslverr)
		else $error("no error on result write");
	mapped_ok_a: assert property (setup_s ##1 (pready && !pwrite && paddr <= 8'h14
		&& paddr[1:0] == 2'h0) |-> !pslverr) else $error("error on mapped read");
	rsvd_zero_a: assert property (rd_ctrl_s |-> prdata[7:6] == 2'h0 && !prdata[3])
		else $error("reserved bits set");
	upper_zero_a: assert property (rd_ctrl_s |-> prdata[31:8] == 24'h0)
		else $error("upper bits set");
	err_rdy_a: assert property (pslverr |-> pready)
		else $error("error flag without ready");
	mask_off_a: assert property (pready && penable && pwrite && paddr == 8'h14 && pstrb[0]
		&& !pwdata[0] |=> ##1 !irq) else $error("irq despite mask");
endmodule

bind dcm_top dcm_properties dcm_properties_inst (.*);

// file: bench/dcm_dec_model.sv
// decoder-side model: sync bit pulses at fixed spacing per channel
module dcm_dec_model
(
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        reset_n,
	// decoder outputs
	output logic [2:0]      dec_sync_bit,
	output logic [2:0]      dec_locked
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] phase_r;
	logic [4:0] phase_nxt;
	always_comb
		phase_nxt = (phase_r == 5'h13) ? 5'h00 : phase_r + 5'h01;
	always_ff @(posedge ref_clk or negedge reset_n)
		if (!reset_n)
			phase_r <= 5'h00;
		else
			phase_r <= phase_nxt;
	// channel 0 every 4 clocks, 1 every 5; channel 2 switched off
	assign dec_sync_bit = {1'b0, (phase_r % 5'h05) == 5'h00, phase_r[1:0] == 2'h0};
	assign dec_locked = 3'h3;
endmodule

// file: bench/tb_dcm_top.sv
// self-checking bench for the decoder clock measurement unit
module tb_dcm_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, ref_32k = 0;
	logic [7:0]  paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd, cnt;
	logic [3:0]  pstrb = 4'hf;
	logic [2:0]  dec_sync_bit, dec_locked;
	logic        pready, pslverr, irq, er;
	int          err_count = 0, tests_run = 0, ref_cnt = 0;
	always #2 ref_clk = ~ref_clk;
	// 5 clocks per level, well above the synchroniser depth
	always @(posedge ref_clk)
	begin
		ref_cnt <= (ref_cnt == 4) ? 0 : ref_cnt + 1;
		if (ref_cnt == 4)
			ref_32k <= ~ref_32k;
	end
	dcm_top dcm_top_inst (.ref_clk(ref_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .dec_sync_bit(dec_sync_bit),
		.dec_locked(dec_locked), .ref_32k(ref_32k), .irq(irq));
	dcm_dec_model dcm_dec_model_inst (.ref_clk(ref_clk), .reset_n(reset_n),
		.dec_sync_bit(dec_sync_bit), .dec_locked(dec_locked));
	task finish_test;
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// no cycle limit here; only the watchdog ends a hung transfer
		@(posedge ref_clk);
		while (pready !== 1'b1)
		begin
			n++;
			@(posedge ref_clk);
		end
		chk("wait states", 32'h0, n);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, exp, rd);
	endtask
	// polls until the count lands; start jitter allows a few counts of slack
	task meas(input logic [7:0] a, input logic [1:0] s, input logic [31:0] exp);
		int n;
		n = 0;
		apb(1'b1, a, {26'h0, s, 4'h0});
		rdchk("busy", 8'h08, 32'h0);
		do
			apb(1'b0, 8'h08, 32'h0);
		while (rd === 32'h0 && ++n < 4000);
		chk("count", 32'h1, {31'h0, rd + 32'h4 >= exp && rd <= exp + 32'h4});
	endtask
	initial
	begin
		repeat (10) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		rdchk("ctrl copy 0", 8'h00, 32'h33);
		rdchk("ctrl copy 1", 8'h04, 32'h33);
		rdchk("result", 8'h08, 32'h0);
		apb(1'b1, 8'h08, 32'h5);
		chk("result write", 32'h1, {31'h0, er});
		apb(1'b0, 8'h18, 32'h0);
		chk("unmapped", 32'h1, {31'h0, er});
		apb(1'b1, 8'h14, 32'h1);
		meas(8'h00, 2'h0, 32'h500);
		cnt = rd;
		chk("irq", 32'h1, {31'h0, irq});
		apb(1'b1, 8'h10, 32'h1);
		@(posedge ref_clk);
		chk("irq clear", 32'h0, {31'h0, irq});
		rdchk("held", 8'h08, cnt);
		apb(1'b1, 8'h00, 32'h30);
		rdchk("no start", 8'h08, cnt);
		apb(1'b1, 8'h0c, 32'h1);
		pstrb <= 4'he;
		apb(1'b1, 8'h0c, 32'h0);
		pstrb <= 4'hf;
		rdchk("strobe off", 8'h0c, 32'h1);
		apb(1'b1, 8'h00, 32'h0);
		rdchk("idle copy", 8'h00, 32'h3);
		rdchk("no effect", 8'h08, cnt);
		meas(8'h04, 2'h1, 32'h400);
		chk("irq again", 32'h1, {31'h0, irq});
		apb(1'b1, 8'h14, 32'h0);
		@(posedge ref_clk);
		chk("irq masked", 32'h0, {31'h0, irq});
		rdchk("stat kept", 8'h10, 32'h1);
		meas(8'h04, 2'h2, 32'h0);
		finish_test;
	end
	// two windows plus the silent poll take about 25k cycles; allow twice that
	initial
	begin
		#200000;
		err_count++;
		finish_test;
	end
endmodule
